// File: rtl/ledmx_regs.sv
// led matrix driver: spi register bank, scan and pwm engine
// Behaviour
// - page 0 holds 72 duty bytes, reset zero
// - dot on time is duty over 256
// - page 1 holds 72 scaling bytes, reset zero
// - global level at 51h scales peak current
// - config 50h: scan, unused, detect, shutdown fields
// - shutdown while bit zero, reset zero
// - detect select: 00 off, 01/11 open, 10 short
// - open pass once, rearm via 00
// - short pass once, rearm via 00
// - scan four, three or two rows
// - code 0011 static sinks, no scan
// - pull select at 52h resets to 33h
// - read-only fault results 53h to 5Eh
// - thermal 5Fh and dither 60h read-write
// - 8Fh write-only reset register
// - write-only unlock E0h and frequency E2h
// - command byte: rw, chip id, page
// - address advances after each data byte
// - full reset only for value AEh
// - frequency applies only while unlocked
module ledmx_regs
    import ledmx_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [17:0] column_open,
    input wire logic [17:0] column_short,
    output logic [3:0] row_switch,
    output logic [17:0] column_sink,
    output logic [7:0] column_level,
    output logic [7:0] global_current_level,
    output logic [7:0] pull_resistor_select,
    output logic [7:0] thermal_status,
    output logic [7:0] clock_dither_control,
    output logic [2:0] freq_active
);
    import ledmx_pkg::*;

    // ---------------- link domain: spi shift (clocked by sck) ----------------
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] byte_q;
    logic byte_tgl_q;
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= {shift_q[5:0], spi_mosi};
        end
    end
    // byte word held stable for the system side until next byte completes
    always_ff @(posedge spi_sck or posedge rst) begin
        if (rst) begin
            byte_q <= 8'h00;
            byte_tgl_q <= 1'b0;
        end else if (!spi_cs_n && bit_cnt_q == 3'h7) begin
            byte_q <= {shift_q, spi_mosi};
            byte_tgl_q <= ~byte_tgl_q;
        end
    end
    // read data shifts out on falling edge from a word handed over by toggle
    logic [7:0] rd_word_q;
    logic rd_tgl_q;
    logic rd_tgl_s1, rd_tgl_s2, rd_seen_q;
    logic [7:0] miso_sh_q;
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            miso_sh_q <= 8'h00;
            rd_tgl_s1 <= 1'b0;
            rd_tgl_s2 <= 1'b0;
            rd_seen_q <= 1'b0;
        end else begin
            rd_tgl_s1 <= rd_tgl_q;
            rd_tgl_s2 <= rd_tgl_s1;
            if (bit_cnt_q == 3'h0) begin
                miso_sh_q <= rd_word_q;
                rd_seen_q <= rd_tgl_s2;
            end else begin
                miso_sh_q <= {miso_sh_q[6:0], 1'b0};
            end
        end
    end
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso <= (bit_cnt_q == 3'h0) ? rd_word_q[7] : miso_sh_q[6];
            spi_miso_oe <= 1'b1;
        end
    end

    // ---------------- system domain: synchronisers ----------------
    logic tgl_s1, tgl_s2, tgl_s3;
    logic cs_s1, cs_s2;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
        end else begin
            tgl_s1 <= byte_tgl_q;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            cs_s1 <= spi_cs_n;
            cs_s2 <= cs_s1;
        end
    end
    logic byte_evt;
    assign byte_evt = tgl_s2 ^ tgl_s3;

    // ---------------- transaction decode ----------------
    ledmx_phase_type phase_q;
    logic rd_q, page_q, sel_ok_q;
    logic [7:0] addr_q;
    logic wr_stb;
    logic soft_rst;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_q <= LEDMX_CMD;
            rd_q <= 1'b0;
            page_q <= 1'b0;
            sel_ok_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (cs_s2) begin
            phase_q <= LEDMX_CMD;
        end else if (byte_evt) begin
            unique case (phase_q)
                LEDMX_CMD: begin
                    rd_q <= byte_q[7];
                    page_q <= (byte_q[3:0] == PAGE_FUNC);
                    sel_ok_q <= byte_q[6:4] == CHIP_ID &&
                        (byte_q[3:0] == PAGE_DUTY || byte_q[3:0] == PAGE_FUNC);
                    phase_q <= LEDMX_ADDR;
                end
                LEDMX_ADDR: begin
                    addr_q <= byte_q;
                    phase_q <= LEDMX_DATA;
                end
                LEDMX_DATA: begin
                    addr_q <= addr_q + 8'h01;
                end
            endcase
        end
    end
    assign wr_stb = byte_evt && phase_q == LEDMX_DATA && !rd_q && sel_ok_q && !cs_s2;

    function automatic logic is_dot(input logic [7:0] a);
        return a >= DOT_FIRST && a <= DOT_LAST;
    endfunction : is_dot

    // ---------------- register storage ----------------
    logic [7:0] duty_q [DOTS];
    logic [7:0] scale_q [DOTS];
    logic [7:0] cfg_q, gcl_q, pull_q, therm_q, dither_q, unlock_q, freq_q;
    logic [5:0] fault_q [FAULT_REGS];
    logic [6:0] widx;
    assign widx = 7'(addr_q - DOT_FIRST);
    assign soft_rst = wr_stb && page_q && addr_q == SRST_OFF && byte_q == SRST_KEY;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DOTS; i++) begin
                duty_q[i] <= 8'h00;
                scale_q[i] <= 8'h00;
            end
        end else if (soft_rst) begin
            for (int i = 0; i < DOTS; i++) begin
                duty_q[i] <= 8'h00;
                scale_q[i] <= 8'h00;
            end
        end else if (wr_stb && is_dot(addr_q)) begin
            if (page_q) begin
                scale_q[widx] <= byte_q;
            end else begin
                duty_q[widx] <= byte_q;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= 8'h00;
            gcl_q <= 8'h00;
            pull_q <= PULL_RESET;
            therm_q <= 8'h00;
            dither_q <= 8'h00;
            unlock_q <= 8'h00;
            freq_q <= 8'h00;
        end else if (soft_rst) begin
            cfg_q <= 8'h00;
            gcl_q <= 8'h00;
            pull_q <= PULL_RESET;
            therm_q <= 8'h00;
            dither_q <= 8'h00;
            unlock_q <= 8'h00;
            freq_q <= 8'h00;
        end else if (wr_stb && page_q) begin
            unique case (addr_q)
                CFG_OFF: cfg_q <= byte_q & CFG_MASK;
                GCL_OFF: gcl_q <= byte_q;
                PULL_OFF: pull_q <= byte_q;
                THERM_OFF: therm_q <= byte_q & THERM_MASK;
                DITHER_OFF: dither_q <= byte_q & DITHER_MASK;
                UNLOCK_OFF: unlock_q <= {7'h00, byte_q[0]};
                FREQ_OFF: freq_q <= byte_q & FREQ_MASK;
                default: ;
            endcase
        end
    end

    // read word captured on each data-phase boundary, handed to link by toggle
    logic [7:0] rd_d;
    logic [6:0] ridx;
    logic [7:0] raddr;
    assign raddr = (phase_q == LEDMX_ADDR) ? byte_q : addr_q + 8'h01;
    assign ridx = 7'(raddr - DOT_FIRST);
    always_comb begin
        rd_d = 8'h00;
        if (is_dot(raddr)) begin
            rd_d = page_q ? scale_q[ridx] : duty_q[ridx];
        end else if (page_q) begin
            unique case (raddr)
                CFG_OFF: rd_d = cfg_q;
                GCL_OFF: rd_d = gcl_q;
                PULL_OFF: rd_d = pull_q;
                THERM_OFF: rd_d = therm_q;
                DITHER_OFF: rd_d = dither_q;
                default: begin
                    if (raddr >= FAULT_FIRST && raddr <= FAULT_LAST) begin
                        rd_d = {2'h0, fault_q[4'(raddr - FAULT_FIRST)]};
                    end
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_word_q <= 8'h00;
            rd_tgl_q <= 1'b0;
        end else if (byte_evt && rd_q && phase_q != LEDMX_CMD && !cs_s2) begin
            rd_word_q <= rd_d;
            rd_tgl_q <= ~rd_tgl_q;
        end
    end

    // ---------------- fault detection passes ----------------
    ledmx_det_type det_q;
    logic armed_q;
    logic [5:0] det_cnt_q;
    logic [1:0] det_sel;
    logic [17:0] col_open_s1, col_open_s2, col_short_s1, col_short_s2;
    assign det_sel = cfg_q[2:1];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            col_open_s1 <= '0;
            col_open_s2 <= '0;
            col_short_s1 <= '0;
            col_short_s2 <= '0;
        end else begin
            col_open_s1 <= column_open;
            col_open_s2 <= col_open_s1;
            col_short_s1 <= column_short;
            col_short_s2 <= col_short_s1;
        end
    end
    // one pass per arming; arming only returns once select reads 00
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            det_q <= LEDMX_IDLE;
            armed_q <= 1'b1;
            det_cnt_q <= 6'h00;
        end else if (soft_rst) begin
            det_q <= LEDMX_IDLE;
            armed_q <= 1'b1;
            det_cnt_q <= 6'h00;
        end else begin
            unique case (det_q)
                LEDMX_IDLE: begin
                    if (det_sel == DET_OFF) begin
                        armed_q <= 1'b1;
                    end else if (armed_q) begin
                        armed_q <= 1'b0;
                        det_cnt_q <= 6'h00;
                        det_q <= (det_sel == DET_SHORT) ? LEDMX_SHORT : LEDMX_OPEN;
                    end
                end
                default: begin
                    det_cnt_q <= det_cnt_q + 6'h01;
                    if (det_cnt_q == 6'(DET_CYCLES - 1)) begin
                        det_q <= LEDMX_IDLE;
                    end
                end
            endcase
        end
    end
    // results latched at pass end; each row gets three 6-column registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < FAULT_REGS; i++) fault_q[i] <= 6'h00;
        end else if (soft_rst) begin
            for (int i = 0; i < FAULT_REGS; i++) fault_q[i] <= 6'h00;
        end else if (det_q != LEDMX_IDLE && det_cnt_q == 6'(DET_CYCLES - 1)) begin
            for (int i = 0; i < FAULT_REGS; i++) begin
                fault_q[i] <= (det_q == LEDMX_OPEN)
                    ? col_open_s2[6 * (i % 3) +: 6] & FAULT_MASK[5:0]
                    : col_short_s2[6 * (i % 3) +: 6];
            end
        end
    end

    // ---------------- scan and pwm engine ----------------
    logic [1:0] row_q;
    logic [7:0] slot_q;
    logic [1:0] last_row;
    always_comb begin
        unique case (cfg_q[7:4])
            SCAN_3: last_row = 2'h2;
            SCAN_2: last_row = 2'h1;
            default: last_row = 2'h3;
        endcase
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slot_q <= 8'h00;
            row_q <= 2'h0;
        end else begin
            slot_q <= slot_q + 8'h01;
            if (slot_q == 8'(SLOT_CYCLES - 1)) begin
                row_q <= (row_q >= last_row) ? 2'h0 : row_q + 2'h1;
            end
        end
    end
    logic run;
    logic stat;
    assign run = cfg_q[0];
    assign stat = cfg_q[7:4] == SCAN_STATIC;
    logic [17:0] sink_d;
    always_comb begin
        for (int c = 0; c < 18; c++) begin
            sink_d[c] = stat ? 1'b1 : (slot_q < duty_q[7'(row_q) * 7'd18 + 7'(c)]);
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            row_switch <= 4'h0;
            column_sink <= 18'h0;
            column_level <= 8'h00;
            global_current_level <= 8'h00;
            pull_resistor_select <= PULL_RESET;
            thermal_status <= 8'h00;
            clock_dither_control <= 8'h00;
            freq_active <= 3'h0;
        end else begin
            row_switch <= (run && !stat && row_q <= last_row) ? 4'(4'h1 << row_q) : 4'h0;
            column_sink <= run ? sink_d : 18'h0;
            column_level <= scale_q[7'(row_q) * 7'd18];
            global_current_level <= gcl_q;
            pull_resistor_select <= pull_q;
            thermal_status <= therm_q;
            clock_dither_control <= dither_q;
            if (soft_rst) begin
                freq_active <= 3'h0;
            end else if (unlock_q[0]) begin
                freq_active <= freq_q[7:5];
            end
        end
    end

    // ---------------- checks ----------------
    shutdown_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg_q[0] |=> row_switch == 4'h0 && column_sink == 18'h0)
        else $error("outputs active in shutdown");
    static_rows_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_q[7:4] == SCAN_STATIC |=> row_switch == 4'h0)
        else $error("rows scanned in static mode");
    row_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_q[7:4] == SCAN_2 && $stable(cfg_q) |=> !row_switch[3])
        else $error("unused row active");
    freq_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
        !unlock_q[0] && !soft_rst |=> $stable(freq_active))
        else $error("frequency changed while locked");
    soft_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
        soft_rst |=> cfg_q == 8'h00 && pull_q == PULL_RESET && duty_q[0] == 8'h00)
        else $error("soft reset incomplete");
    cfg_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg_q[3] && therm_q[7:4] == 4'h0 && unlock_q[7:1] == 7'h00)
        else $error("unused bits set");
    one_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        det_q != LEDMX_IDLE && $past(det_q) == LEDMX_IDLE |-> !armed_q)
        else $error("pass started without disarm");
    pass_length_a: assert property (@(posedge sys_clk) disable iff (rst)
        det_q == LEDMX_IDLE ##1 det_q != LEDMX_IDLE |-> ##[63:64] det_q == LEDMX_IDLE)
        else $error("detection pass length wrong");
    addr_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        byte_evt && phase_q == LEDMX_DATA && !cs_s2 |=> addr_q == $past(addr_q) + 8'h01)
        else $error("address did not advance");
    open_pass_c: cover property (@(posedge sys_clk) det_q == LEDMX_OPEN);
    short_pass_c: cover property (@(posedge sys_clk) det_q == LEDMX_SHORT);
    soft_reset_c: cover property (@(posedge sys_clk) soft_rst);
    read_c: cover property (@(posedge sys_clk) rd_q && byte_evt && phase_q == LEDMX_DATA);
endmodule : ledmx_regs

// File: rtl/ledmx_pkg.sv
// constants and types for the led matrix register bank
package ledmx_pkg;
    localparam logic [2:0] CHIP_ID = 3'h5; // arbitrary identifier value
    localparam logic [3:0] PAGE_DUTY = 4'h0;
    localparam logic [3:0] PAGE_FUNC = 4'h1;
    localparam logic [7:0] DOT_FIRST = 8'h01;
    localparam logic [7:0] DOT_LAST = 8'h48;
    localparam logic [7:0] CFG_OFF = 8'h50;
    localparam logic [7:0] GCL_OFF = 8'h51;
    localparam logic [7:0] PULL_OFF = 8'h52;
    localparam logic [7:0] FAULT_FIRST = 8'h53;
    localparam logic [7:0] FAULT_LAST = 8'h5E;
    localparam logic [7:0] THERM_OFF = 8'h5F;
    localparam logic [7:0] DITHER_OFF = 8'h60;
    localparam logic [7:0] SRST_OFF = 8'h8F;
    localparam logic [7:0] UNLOCK_OFF = 8'hE0;
    localparam logic [7:0] FREQ_OFF = 8'hE2;
    localparam logic [7:0] SRST_KEY = 8'hAE;
    localparam logic [7:0] PULL_RESET = 8'h33;
    localparam logic [7:0] CFG_MASK = 8'hF7;
    localparam logic [7:0] THERM_MASK = 8'h0F;
    localparam logic [7:0] DITHER_MASK = 8'h1F;
    localparam logic [7:0] FREQ_MASK = 8'hE0;
    localparam logic [7:0] FAULT_MASK = 8'h3F;
    localparam int DOTS = 72;
    localparam int FAULT_REGS = 12;
    localparam int SLOT_CYCLES = 256;
    localparam int DET_CYCLES = 64;
    localparam logic [1:0] DET_OFF = 2'h0;
    localparam logic [1:0] DET_SHORT = 2'h2;
    localparam logic [3:0] SCAN_3 = 4'h1;
    localparam logic [3:0] SCAN_2 = 4'h2;
    localparam logic [3:0] SCAN_STATIC = 4'h3;
    typedef enum logic [1:0] {LEDMX_CMD, LEDMX_ADDR, LEDMX_DATA} ledmx_phase_type;
    typedef enum logic [1:0] {LEDMX_IDLE, LEDMX_OPEN, LEDMX_SHORT} ledmx_det_type;
endpackage : ledmx_pkg

// File: verif/ledmx_spi_master.sv
// spi master model driving the led matrix register bank
module ledmx_spi_master (
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    int hold_ns = 200;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // last high phase stretched: the slave fetches read data before the next fall
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            #40;
            spi_sck = 1'b1;
            rx[i] = spi_miso;
            #(i == 0 ? 40 + hold_ns : 40);
            spi_sck = 1'b0;
        end
    endtask : xfer_byte
    task automatic open_frame(input logic rd, input logic [2:0] id, input logic [3:0] pg,
        input logic [7:0] a);
        logic [7:0] d;
        spi_cs_n = 1'b0;
        #100;
        xfer_byte({rd, id, pg}, d);
        xfer_byte(a, d);
    endtask : open_frame
    task automatic close_frame;
        #100;
        spi_cs_n = 1'b1;
        // released data line must not keep looking valid
        spi_mosi = ~spi_mosi;
        #200;
    endtask : close_frame
endmodule : ledmx_spi_master

// File: verif/tb.sv
// self-checking bench for the led matrix register bank
module tb;
    import ledmx_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst, sck, cs_n, mosi, miso, miso_oe, miso_w;
    logic [17:0] c_open, c_short, sink;
    logic [3:0] rows;
    logic [7:0] lvl, gcl, pull, therm, dith, r;
    logic [2:0] freq;
    int n_mismatch = 0;
    int checks_done = 0;
    ledmx_regs dut_u (.sys_clk(sys_clk), .rst(rst), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .column_open(c_open),
        .column_short(c_short), .row_switch(rows), .column_sink(sink), .column_level(lvl),
        .global_current_level(gcl), .pull_resistor_select(pull), .thermal_status(therm),
        .clock_dither_control(dith), .freq_active(freq));
    // undriven line shows the inverse of miso, which clears to low, so it reads high
    assign miso_w = miso_oe ? miso : ~miso;
    ledmx_spi_master m_u (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso_w));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] e);
        checks_done++;
        if (seen !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", w, e, seen);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr_raw(input logic [2:0] id, input logic [3:0] pg, input logic [7:0] a,
        input logic [7:0] d);
        m_u.open_frame(1'b0, id, pg, a);
        m_u.xfer_byte(d, r);
        m_u.close_frame();
    endtask : wr_raw
    task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
        wr_raw(CHIP_ID, pg, a, d);
    endtask : wr
    task automatic rc(input string w, input logic [3:0] pg, input logic [7:0] a,
        input logic [7:0] e);
        logic [7:0] d;
        m_u.open_frame(1'b1, CHIP_ID, pg, a);
        m_u.xfer_byte(8'h00, d);
        m_u.close_frame();
        chk(w, d, e);
    endtask : rc
    task automatic t_reset;
        chk("pull port", pull, PULL_RESET);
        chk("freq port", {5'h00, freq}, 8'h00);
        rc("duty", PAGE_DUTY, DOT_FIRST, 8'h00);
        rc("scale", PAGE_FUNC, DOT_LAST, 8'h00);
        rc("cfg", PAGE_FUNC, CFG_OFF, 8'h00);
        rc("gcl", PAGE_FUNC, GCL_OFF, 8'h00);
        rc("pull", PAGE_FUNC, PULL_OFF, PULL_RESET);
        rc("fault", PAGE_FUNC, FAULT_LAST, 8'h00);
        rc("therm", PAGE_FUNC, THERM_OFF, 8'h00);
        rc("dither", PAGE_FUNC, DITHER_OFF, 8'h00);
    endtask : t_reset
    task automatic t_burst;
        logic [7:0] d;
        m_u.open_frame(1'b0, CHIP_ID, PAGE_DUTY, 8'h46);
        for (int i = 0; i < 3; i++) m_u.xfer_byte(8'hA0 + 8'(i), d);
        m_u.close_frame();
        m_u.open_frame(1'b1, CHIP_ID, PAGE_DUTY, 8'h46);
        for (int i = 0; i < 3; i++) begin
            m_u.xfer_byte(8'h00, d);
            chk("duty burst", d, 8'hA0 + 8'(i));
        end
        m_u.close_frame();
        rc("scale apart", PAGE_FUNC, 8'h46, 8'h00);
        wr(PAGE_FUNC, DOT_FIRST, 8'h5A);
        rc("scale", PAGE_FUNC, DOT_FIRST, 8'h5A);
        rc("duty apart", PAGE_DUTY, DOT_FIRST, 8'h00);
    endtask : t_burst
    task automatic t_masks;
        logic [7:0] a[4] = '{THERM_OFF, DITHER_OFF, GCL_OFF, FAULT_FIRST};
        logic [7:0] e[4] = '{THERM_MASK, DITHER_MASK, 8'hFF, 8'h00};
        for (int i = 0; i < 4; i++) begin
            wr(PAGE_FUNC, a[i], 8'hFF);
            rc("masked reg", PAGE_FUNC, a[i], e[i]);
        end
        chk("therm port", therm, THERM_MASK);
        chk("dither port", dith, DITHER_MASK);
        chk("gcl port", gcl, 8'hFF);
        wr(PAGE_FUNC, CFG_OFF, 8'hF8);
        rc("cfg", PAGE_FUNC, CFG_OFF, 8'hF0);
        wr(PAGE_FUNC, CFG_OFF, 8'h00);
    endtask : t_masks
    task automatic t_id;
        wr_raw(~CHIP_ID, PAGE_FUNC, GCL_OFF, 8'h12);
        wr_raw(CHIP_ID, 4'h2, GCL_OFF, 8'h34);
        rc("gcl foreign", PAGE_FUNC, GCL_OFF, 8'hFF);
    endtask : t_id
    task automatic t_freq;
        wr(PAGE_FUNC, FREQ_OFF, 8'hBF);
        chk("freq locked", {5'h00, freq}, 8'h00);
        wr(PAGE_FUNC, UNLOCK_OFF, 8'h01);
        wr(PAGE_FUNC, FREQ_OFF, 8'hBF);
        chk("freq applied", {5'h00, freq}, 8'h05);
        wr(PAGE_FUNC, UNLOCK_OFF, 8'h00);
        wr(PAGE_FUNC, FREQ_OFF, 8'h20);
        chk("freq relocked", {5'h00, freq}, 8'h05);
    endtask : t_freq
    task automatic t_srst;
        wr(PAGE_FUNC, PULL_OFF, 8'h00);
        wr(PAGE_FUNC, SRST_OFF, 8'h55);
        rc("gcl wrong key", PAGE_FUNC, GCL_OFF, 8'hFF);
        wr(PAGE_FUNC, SRST_OFF, SRST_KEY);
        rc("gcl reset", PAGE_FUNC, GCL_OFF, 8'h00);
        rc("duty reset", PAGE_DUTY, 8'h47, 8'h00);
        chk("pull reset", pull, PULL_RESET);
        chk("freq reset", {5'h00, freq}, 8'h00);
    endtask : t_srst
    task automatic watch(input int n, output logic [3:0] seen, output int on, output int mv);
        logic [3:0] last;
        seen = 4'h0;
        on = 0;
        mv = 0;
        // let a slot in progress finish before judging
        repeat (300) @(posedge sys_clk);
        last = rows;
        repeat (n) begin
            @(posedge sys_clk);
            seen |= rows;
            on += int'(sink[0] === 1'b1);
            mv += int'(rows !== last);
            last = rows;
        end
    endtask : watch
    task automatic t_scan;
        logic [3:0] seen;
        int on, mv;
        logic [7:0] d;
        logic [7:0] code[3] = '{8'h11, 8'h21, 8'hF1};
        logic [7:0] e[3] = '{8'h07, 8'h03, 8'h0F};
        wr(PAGE_FUNC, DOT_FIRST, 8'h5A);
        m_u.open_frame(1'b0, CHIP_ID, PAGE_DUTY, DOT_FIRST);
        repeat (DOTS) m_u.xfer_byte(8'h40, d);
        m_u.close_frame();
        watch(1100, seen, on, mv);
        chk("shutdown rows", {4'h0, seen}, 8'h00);
        chk("shutdown sink", {7'h00, on == 0}, 8'h01);
        wr(PAGE_FUNC, CFG_OFF, 8'h01);
        watch(2048, seen, on, mv);
        chk("rows quarter", {4'h0, seen}, 8'h0F);
        chk("duty on time", {7'h00, on >= 504 && on <= 520}, 8'h01);
        while (rows !== 4'h1) begin
            @(posedge sys_clk);
            #1;
        end
        chk("column level", lvl, 8'h5A);
        for (int i = 0; i < 3; i++) begin
            wr(PAGE_FUNC, CFG_OFF, code[i]);
            watch(1100, seen, on, mv);
            chk("rows used", {4'h0, seen}, e[i]);
        end
        wr(PAGE_FUNC, CFG_OFF, 8'h31);
        watch(1100, seen, on, mv);
        chk("static rows", {7'h00, mv == 0}, 8'h01);
        chk("static rows off", {4'h0, seen}, 8'h00);
        chk("static sinks", {7'h00, on == 1100}, 8'h01);
    endtask : t_scan
    task automatic det(input logic [7:0] cfg, input logic [17:0] op, input logic [7:0] e);
        @(posedge sys_clk);
        #1;
        c_open = op;
        c_short = ~op;
        wr(PAGE_FUNC, CFG_OFF, cfg);
        repeat (DET_CYCLES + 40) @(posedge sys_clk);
        rc("fault result", PAGE_FUNC, FAULT_FIRST, e);
    endtask : det
    task automatic t_detect;
        det(8'h03, 18'h00015, 8'h15);
        det(8'h03, 18'h0002A, 8'h15);
        det(8'h01, 18'h0002A, 8'h15);
        det(8'h03, 18'h0002A, 8'h2A);
        det(8'h01, 18'h0000C, 8'h2A);
        det(8'h05, 18'h0000C, 8'h33);
        det(8'h05, 18'h00015, 8'h33);
        det(8'h01, 18'h00015, 8'h33);
        det(8'h07, 18'h00015, 8'h15);
    endtask : t_detect
    initial begin
        rst = 1'b1;
        c_open = 18'h00000;
        c_short = 18'h00000;
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (6) @(posedge sys_clk);
        t_reset();
        t_burst();
        t_masks();
        t_id();
        t_freq();
        t_srst();
        t_scan();
        t_detect();
        report_and_stop();
    end
    initial begin
        #600_000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb
